// ==== hdl/mmu_map.svh ====
// Register locations, field positions and reset values of the segment MMU
`ifndef MMU_MAP_SVH
`define MMU_MAP_SVH

`define MMU_PAGE_NUM        8'h15
`define MMU_DPR_BASE        8'hf0
`define MMU_DPR_RELOC_BASE  8'he0
`define MMU_CSR_OFS         8'hf4
`define MMU_EXTENDED_MODE_REGISTER_TWO_OFS        8'hf6
`define MMU_ISR_OFS         8'hf8
`define MMU_DMA_SEGMENT_OFS       8'hf9
`define MMU_RELOC_BIT       5
`define MMU_SAVE_BIT        6
`define MMU_CSR_RESET       6'h00
`define MMU_SEG_RESET       6'h00
`define MMU_DPR_RESET       8'h00
`define MMU_ADDR_RESET      22'h000000
`define MMU_DEPTH_W         4

`endif

// ==== hdl/mmu_pkg.sv ====
// Types shared by the segment MMU files
package mmu_pkg;
   typedef logic [5:0]  seg_t;
   typedef logic [7:0]  page_t;
   typedef logic [7:0]  byte_t;
   typedef logic [15:0] vaddr_t;
   typedef logic [21:0] paddr_t;
endpackage

// ==== hdl/seg_if.sv ====
// Segment and page state passed from the register block to the translator
`timescale 1ns/1ps
interface seg_if;
   import mmu_pkg::*;
   seg_t  code_seg;
   seg_t  int_seg;
   seg_t  dma_seg;
   page_t data_page [4];
   logic  use_isr;
   modport owner (output code_seg, output int_seg, output dma_seg, output data_page, output use_isr);
   modport user  (input code_seg, input int_seg, input dma_seg, input data_page, input use_isr);
endinterface

// ==== hdl/mmu_xlate.sv ====
// Virtual to physical address translation for fetch, data and DMA
`timescale 1ns/1ps
`include "mmu_map.svh"
module mmu_xlate (
   input  wire logic          clock_i,
   input  wire logic          rstn_i,
   seg_if.user                seg,
   input  wire logic          fetch_req_i,
   input  wire logic          fetch_vector_i,
   input  wire mmu_pkg::vaddr_t fetch_vaddr_i,
   input  wire logic          data_req_i,
   input  wire mmu_pkg::vaddr_t data_vaddr_i,
   input  wire logic          dma_req_i,
   input  wire logic          dma_seg_sel_i,
   input  wire mmu_pkg::vaddr_t dma_vaddr_i,
   output logic               fetch_valid_o,
   output mmu_pkg::paddr_t    fetch_paddr_o,
   output logic               data_valid_o,
   output mmu_pkg::paddr_t    data_paddr_o,
   output logic               dma_valid_o,
   output mmu_pkg::paddr_t    dma_paddr_o
);
   import mmu_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Program fetch
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         fetch_valid_o <= 1'b0;
         fetch_paddr_o <= `MMU_ADDR_RESET;
      end else begin
         fetch_valid_o <= fetch_req_i;
         if (fetch_req_i) begin
            if (fetch_vector_i || seg.use_isr) begin
               fetch_paddr_o <= {seg.int_seg, fetch_vaddr_i};
            end else begin
               fetch_paddr_o <= {seg.code_seg, fetch_vaddr_i};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Data paging
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         data_valid_o <= 1'b0;
         data_paddr_o <= `MMU_ADDR_RESET;
      end else begin
         data_valid_o <= data_req_i;
         if (data_req_i) begin
            data_paddr_o <= {seg.data_page[data_vaddr_i[15:14]], data_vaddr_i[13:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // DMA segment
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         dma_valid_o <= 1'b0;
         dma_paddr_o <= `MMU_ADDR_RESET;
      end else begin
         dma_valid_o <= dma_req_i;
         if (dma_req_i) begin
            dma_paddr_o <= {dma_seg_sel_i ? seg.dma_seg : seg.int_seg, dma_vaddr_i};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   fetch_code_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      fetch_req_i && !fetch_vector_i && !seg.use_isr |=>
      fetch_valid_o && fetch_paddr_o == {$past(seg.code_seg), $past(fetch_vaddr_i)})
      else $error("fetch address not formed from code segment");
   fetch_vector_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      fetch_req_i && (fetch_vector_i || seg.use_isr) |=> fetch_paddr_o[21:16] == $past(seg.int_seg))
      else $error("vector or handler fetch not in interrupt segment");
   data_page_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      data_req_i |=> data_valid_o && data_paddr_o[13:0] == $past(data_vaddr_i[13:0])
      && data_paddr_o[21:14] == $past(seg.data_page[data_vaddr_i[15:14]]))
      else $error("data page translation wrong");
   dma_isr_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      dma_req_i && !dma_seg_sel_i |=> dma_paddr_o[21:16] == $past(seg.int_seg))
      else $error("dma did not use interrupt segment");
   dma_dmaseg_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      dma_req_i && dma_seg_sel_i |=> dma_paddr_o == {$past(seg.dma_seg), $past(dma_vaddr_i)})
      else $error("dma did not use dma segment");
endmodule

// ==== hdl/mmu_segment.sv ====
// Segment MMU: segment and page registers, interrupt segment handling
`timescale 1ns/1ps
`include "mmu_map.svh"
module mmu_segment (
   input  wire logic            clock_i,
   input  wire logic            rstn_i,
   input  wire logic            reg_wr_i,
   input  wire logic            reg_rd_i,
   input  wire mmu_pkg::byte_t  reg_page_i,
   input  wire mmu_pkg::byte_t  reg_addr_i,
   input  wire mmu_pkg::byte_t  reg_wdata_i,
   output mmu_pkg::byte_t       reg_rdata_o,
   output logic                 reg_hit_o,
   output logic                 port_hit_o,
   input  wire logic            int_entry_i,
   input  wire logic            int_return_i,
   input  wire mmu_pkg::seg_t   pop_seg_i,
   input  wire logic            far_load_i,
   input  wire mmu_pkg::seg_t   far_seg_i,
   output logic                 seg_push_o,
   output mmu_pkg::seg_t        seg_push_data_o,
   output logic                 isr_active_o,
   input  wire logic            fetch_req_i,
   input  wire logic            fetch_vector_i,
   input  wire mmu_pkg::vaddr_t fetch_vaddr_i,
   input  wire logic            data_req_i,
   input  wire mmu_pkg::vaddr_t data_vaddr_i,
   input  wire logic            dma_req_i,
   input  wire logic            dma_seg_sel_i,
   input  wire mmu_pkg::vaddr_t dma_vaddr_i,
   output logic                 fetch_valid_o,
   output mmu_pkg::paddr_t      fetch_paddr_o,
   output logic                 data_valid_o,
   output mmu_pkg::paddr_t      data_paddr_o,
   output logic                 dma_valid_o,
   output mmu_pkg::paddr_t      dma_paddr_o
);
   import mmu_pkg::*;

   seg_if seg ();

   seg_t                    code_seg_q;
   seg_t                    int_seg_q;
   seg_t                    dma_seg_q;
   page_t                   data_page_q [4];
   logic                    reloc_q;
   logic                    save_en_q;
   logic                    save_en_d;
   logic [`MMU_DEPTH_W-1:0] depth_q;
   logic [`MMU_DEPTH_W-1:0] depth_d;
   logic                    use_isr_q;
   logic                    access;
   logic                    in_page21;
   logic                    group_e;
   logic                    group_f;
   logic                    sel_dpr;
   logic                    sel_port;
   logic                    sel_csr;
   logic                    sel_extended_mode_register_two;
   logic                    sel_isr;
   logic                    sel_dma;
   byte_t                   rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   always_comb begin
      access    = reg_wr_i || reg_rd_i;
      in_page21 = reg_page_i == `MMU_PAGE_NUM;
      group_e   = {reg_addr_i[7:2], 2'b00} == `MMU_DPR_RELOC_BASE;
      group_f   = in_page21 && ({reg_addr_i[7:2], 2'b00} == `MMU_DPR_BASE);
      sel_dpr   = reloc_q ? group_e : group_f;
      sel_port  = reloc_q ? group_f : group_e;
      sel_csr   = in_page21 && reg_addr_i == `MMU_CSR_OFS;
      sel_extended_mode_register_two  = in_page21 && reg_addr_i == `MMU_EXTENDED_MODE_REGISTER_TWO_OFS;
      sel_isr   = in_page21 && reg_addr_i == `MMU_ISR_OFS;
      sel_dma   = in_page21 && reg_addr_i == `MMU_DMA_SEGMENT_OFS;
   end

   always_comb begin
      rdata = 8'h00;
      if (sel_dpr) begin
         rdata = data_page_q[reg_addr_i[1:0]];
      end else if (sel_csr) begin
         rdata = {2'b00, code_seg_q};
      end else if (sel_extended_mode_register_two) begin
         rdata[`MMU_RELOC_BIT] = reloc_q;
         rdata[`MMU_SAVE_BIT]  = save_en_q;
      end else if (sel_isr) begin
         rdata = {2'b00, int_seg_q};
      end else if (sel_dma) begin
         rdata = {2'b00, dma_seg_q};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read port
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         reg_rdata_o <= 8'h00;
         reg_hit_o   <= 1'b0;
         port_hit_o  <= 1'b0;
      end else begin
         if (reg_rd_i) begin
            reg_rdata_o <= rdata;
         end
         reg_hit_o  <= access && (sel_dpr || sel_csr || sel_extended_mode_register_two || sel_isr || sel_dma);
         port_hit_o <= access && sel_port;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Extended mode bits
   always_comb begin
      save_en_d = save_en_q;
      if (reg_wr_i && sel_extended_mode_register_two) begin
         save_en_d = reg_wdata_i[`MMU_SAVE_BIT];
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         reloc_q   <= 1'b0;
         save_en_q <= 1'b0;
      end else begin
         save_en_q <= save_en_d;
         if (reg_wr_i && sel_extended_mode_register_two) begin
            reloc_q <= reg_wdata_i[`MMU_RELOC_BIT];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Segment registers
   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         int_seg_q <= `MMU_SEG_RESET;
         dma_seg_q <= `MMU_SEG_RESET;
      end else begin
         if (reg_wr_i && sel_isr) begin
            int_seg_q <= reg_wdata_i[5:0];
         end
         if (reg_wr_i && sel_dma) begin
            dma_seg_q <= reg_wdata_i[5:0];
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         code_seg_q <= `MMU_CSR_RESET;
      end else if (int_entry_i && save_en_q) begin
         code_seg_q <= int_seg_q;
      end else if (int_return_i && save_en_q) begin
         code_seg_q <= pop_seg_i;
      end else if (far_load_i) begin
         code_seg_q <= far_seg_i;
      end else if (reg_wr_i && sel_csr) begin
         code_seg_q <= reg_wdata_i[5:0];
      end
   end

   generate
      for (genvar i = 0; i < 4; i++) begin : g_page
         always_ff @(posedge clock_i) begin
            if (!rstn_i) begin
               data_page_q[i] <= `MMU_DPR_RESET;
            end else if (reg_wr_i && sel_dpr && reg_addr_i[1:0] == 2'(i)) begin
               data_page_q[i] <= reg_wdata_i;
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt nesting and stack push
   always_comb begin
      depth_d = depth_q;
      if (int_entry_i && !int_return_i && depth_q != '1) begin
         depth_d = depth_q + 1'b1;
      end else if (int_return_i && !int_entry_i && depth_q != '0) begin
         depth_d = depth_q - 1'b1;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         depth_q      <= '0;
         use_isr_q    <= 1'b0;
         isr_active_o <= 1'b0;
      end else begin
         depth_q      <= depth_d;
         use_isr_q    <= depth_d != '0 && !save_en_d;
         isr_active_o <= depth_d != '0;
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rstn_i) begin
         seg_push_o      <= 1'b0;
         seg_push_data_o <= `MMU_SEG_RESET;
      end else begin
         seg_push_o      <= int_entry_i && save_en_q;
         seg_push_data_o <= code_seg_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Translator
   assign seg.code_seg  = code_seg_q;
   assign seg.int_seg   = int_seg_q;
   assign seg.dma_seg   = dma_seg_q;
   assign seg.data_page = data_page_q;
   assign seg.use_isr   = use_isr_q;

   mmu_xlate u_xlate (
      .clock_i        (clock_i),
      .rstn_i         (rstn_i),
      .seg            (seg.user),
      .fetch_req_i    (fetch_req_i),
      .fetch_vector_i (fetch_vector_i),
      .fetch_vaddr_i  (fetch_vaddr_i),
      .data_req_i     (data_req_i),
      .data_vaddr_i   (data_vaddr_i),
      .dma_req_i      (dma_req_i),
      .dma_seg_sel_i  (dma_seg_sel_i),
      .dma_vaddr_i    (dma_vaddr_i),
      .fetch_valid_o  (fetch_valid_o),
      .fetch_paddr_o  (fetch_paddr_o),
      .data_valid_o   (data_valid_o),
      .data_paddr_o   (data_paddr_o),
      .dma_valid_o    (dma_valid_o),
      .dma_paddr_o    (dma_paddr_o)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   save_default_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      !$past(rstn_i) |-> !save_en_q && !use_isr_q)
      else $error("save enable not clear after reset");
   entry_push_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      int_entry_i && save_en_q |=> seg_push_o && seg_push_data_o == $past(code_seg_q)
      && code_seg_q == $past(int_seg_q))
      else $error("entry did not push and reload code segment");
   compat_entry_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      int_entry_i && !int_return_i && !save_en_q && !(reg_wr_i && sel_extended_mode_register_two) |=> !seg_push_o && use_isr_q)
      else $error("compatible entry pushed segment or left code segment in use");
   iret_restore_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      int_return_i && save_en_q && !int_entry_i |=> code_seg_q == $past(pop_seg_i))
      else $error("return did not restore code segment");
   far_load_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      far_load_i && !(save_en_q && (int_entry_i || int_return_i)) |=> code_seg_q == $past(far_seg_i))
      else $error("far transfer did not load code segment");
   far_in_isr_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      use_isr_q && far_load_i && !int_return_i ##[1:2] fetch_req_i && !fetch_vector_i && use_isr_q
      |=> fetch_paddr_o[21:16] == $past(int_seg_q))
      else $error("far transfer in compatible handler moved the fetch");
   reloc_swap_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      reg_rd_i && reloc_q && group_e |=> reg_hit_o && !port_hit_o
      && reg_rdata_o == $past(data_page_q[reg_addr_i[1:0]]))
      else $error("relocated page register not found in group E");
   reserved_zero_a : assert property (@(posedge clock_i) disable iff (!rstn_i)
      reg_rd_i && (sel_csr || sel_isr || sel_dma) |=> reg_rdata_o[7:6] == 2'b00)
      else $error("reserved segment bits read non-zero");
endmodule

// ==== verification/cpu_dma_model.sv ====
// CPU core and DMA controller model driving the segment MMU
`timescale 1ns/1ps
module cpu_dma_model (
   input  wire logic   clock_i,
   output logic        wr_o,
   output logic        rd_o,
   output logic [7:0]  page_o,
   output logic [7:0]  addr_o,
   output logic [7:0]  wdata_o,
   output logic [2:0]  evt_o,
   output logic [5:0]  seg_o,
   output logic [2:0]  req_o,
   output logic        flag_o,
   output logic [15:0] vaddr_o
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      page_o = 8'h00;
      addr_o = 8'h00;
      wdata_o = 8'h00;
      evt_o = 3'h0;
      seg_o = 6'h00;
      req_o = 3'h0;
      flag_o = 1'b0;
      vaddr_o = 16'h0000;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register access: one strobe cycle, then the strobes drop and the write data is inverted
   task automatic access(input logic w, input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      #1;
      wr_o = w;
      rd_o = ~w;
      page_o = p;
      addr_o = a;
      wdata_o = d;
      @(posedge clock_i);
      #1;
      wr_o = 1'b0;
      rd_o = 1'b0;
      wdata_o = ~d;
   endtask

   // Event or translation request: one pulse cycle
   task automatic pulse(input logic [2:0] e, input logic [2:0] r, input logic f, input logic [5:0] s,
                        input logic [15:0] v);
      @(posedge clock_i);
      #1;
      evt_o = e;
      req_o = r;
      flag_o = f;
      seg_o = s;
      vaddr_o = v;
      @(posedge clock_i);
      #1;
      evt_o = 3'h0;
      req_o = 3'h0;
      seg_o = ~s;
      vaddr_o = ~v;
   endtask
endmodule

// ==== verification/mmu_segment_tb.sv ====
// Self-checking bench for the segment MMU
`timescale 1ns/1ps
`include "mmu_map.svh"
module mmu_segment_tb;
   import mmu_pkg::*;
   logic        clock_i, rstn_i, wr, rd, flag, took, hit, phit, push, act, fv, dv, mv;
   logic [2:0]  evt, req;
   byte_t       page, addr, wdata, rdata;
   seg_t        seg, push_d, cs, interrupt_segment, dsg;
   vaddr_t      vaddr;
   paddr_t      fp, dp, mp;
   byte_t       pg [4];
   logic        save, reloc;
   int          depth, error_cnt, cmp_count;
   logic [10:0] qa [$], ea;
   paddr_t      qf [$], qd [$], qm [$];
   seg_t        qp [$];
   byte_t       ra [8] = '{8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf6, 8'hf8, 8'hf9};

   cpu_dma_model m (.clock_i(clock_i), .wr_o(wr), .rd_o(rd), .page_o(page), .addr_o(addr),
      .wdata_o(wdata), .evt_o(evt), .seg_o(seg), .req_o(req), .flag_o(flag), .vaddr_o(vaddr));

   mmu_segment u_dut (.clock_i(clock_i), .rstn_i(rstn_i), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_page_i(page), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .reg_hit_o(hit), .port_hit_o(phit), .int_entry_i(evt[0]), .int_return_i(evt[1]),
      .pop_seg_i(seg), .far_load_i(evt[2]), .far_seg_i(seg), .seg_push_o(push),
      .seg_push_data_o(push_d), .isr_active_o(act), .fetch_req_i(req[0]), .fetch_vector_i(flag),
      .fetch_vaddr_i(vaddr), .data_req_i(req[1]), .data_vaddr_i(vaddr), .dma_req_i(req[2]),
      .dma_seg_sel_i(flag), .dma_vaddr_i(vaddr), .fetch_valid_o(fv), .fetch_paddr_o(fp),
      .data_valid_o(dv), .data_paddr_o(dp), .dma_valid_o(mv), .dma_paddr_o(mp));

   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Comparison and closing
   task automatic judge(input string what, input paddr_t e, input paddr_t g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %0t %s exp %h got %h", $time, what, e, g);
      end
   endtask
   task automatic cmp_acc(input logic [10:0] e, input logic [10:0] g);
      judge("access", {11'h000, e}, {11'h000, g});
   endtask
   task automatic cmp_addr(input paddr_t e, input paddr_t g);
      judge("address", e, g);
   endtask
   task automatic cmp_seg(input seg_t e, input seg_t g);
      judge("pushed segment", {16'h0000, e}, {16'h0000, g});
   endtask
   task automatic cmp_bit(input logic e, input logic g);
      judge("handler active", {21'h0, e}, {21'h0, g});
   endtask
   task automatic wrap_up();
      if (qa.size() + qf.size() + qd.size() + qm.size() + qp.size() != 0) begin
         error_cnt++;
         $display("mismatch %0t expected results never appeared", $time);
      end
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Watcher: takes the oldest note whenever a result shows
   always @(posedge clock_i) begin
      took = wr | rd;
      #2;
      if (took) begin
         ea = qa.size() ? qa.pop_front() : 'x;
         cmp_acc(ea, {ea[10], hit, phit, ea[10] ? rdata : 8'h00});
      end
      if (fv) cmp_addr(qf.size() ? qf.pop_front() : 'x, fp);
      if (dv) cmp_addr(qd.size() ? qd.pop_front() : 'x, dp);
      if (mv) cmp_addr(qm.size() ? qm.pop_front() : 'x, mp);
      if (push) cmp_seg(qp.size() ? qp.pop_front() : 'x, push_d);
   end

   initial begin
      repeat (20000) @(posedge clock_i);
      error_cnt++;
      $display("mismatch %0t run did not finish", $time);
      wrap_up();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Drivers that note the expected results
   task automatic do_reset();
      rstn_i = 1'b0;
      repeat (2) @(posedge clock_i);
      #1;
      rstn_i = 1'b1;
      cs = 6'h00;
      interrupt_segment = 6'h00;
      dsg = 6'h00;
      save = 1'b0;
      reloc = 1'b0;
      depth = 0;
      pg = '{default: 8'h00};
   endtask

   task automatic acc(input logic w, input byte_t p, input byte_t a, input byte_t d);
      logic  h;
      logic  ph;
      byte_t r;
      h = 1'b1;
      ph = 1'b0;
      r = 8'h00;
      if (reloc && a[7:2] == 6'h38) r = pg[a[1:0]];
      else if (a[7:2] == 6'h38) {h, ph} = 2'b01;
      else if (p != `MMU_PAGE_NUM) h = 1'b0;
      else if (a[7:2] == 6'h3c && reloc) {h, ph} = 2'b01;
      else if (a[7:2] == 6'h3c) r = pg[a[1:0]];
      else if (a == `MMU_CSR_OFS) r = {2'h0, cs};
      else if (a == `MMU_EXTENDED_MODE_REGISTER_TWO_OFS) r = {1'b0, save, reloc, 5'h00};
      else if (a == `MMU_ISR_OFS) r = {2'h0, interrupt_segment};
      else if (a == `MMU_DMA_SEGMENT_OFS) r = {2'h0, dsg};
      else h = 1'b0;
      if (w && h && (a[7:2] == 6'h38 || a[7:2] == 6'h3c)) pg[a[1:0]] = d;
      if (w && h && a == `MMU_CSR_OFS) cs = d[5:0];
      if (w && h && a == `MMU_EXTENDED_MODE_REGISTER_TWO_OFS) {save, reloc} = d[6:5];
      if (w && h && a == `MMU_ISR_OFS) interrupt_segment = d[5:0];
      if (w && h && a == `MMU_DMA_SEGMENT_OFS) dsg = d[5:0];
      qa.push_back({~w, h, ph, w ? 8'h00 : r});
      m.access(w, p, a, d);
   endtask

   task automatic xl(input int k, input logic f, input vaddr_t v);
      case (k)
         0: qf.push_back({(f || (depth > 0 && !save)) ? interrupt_segment : cs, v});
         1: qd.push_back({pg[v[15:14]], v[13:0]});
         default: qm.push_back({f ? dsg : interrupt_segment, v});
      endcase
      m.pulse(3'h0, 3'h1 << k, f, 6'h00, v);
   endtask

   task automatic ev(input int k, input seg_t s);
      if (k == 0 && save) qp.push_back(cs);
      if (k == 0 && save) cs = interrupt_segment;
      if (k == 1 && save) cs = s;
      if (k == 2) cs = s;
      if (k == 0 && depth < 15) depth++;
      if (k == 1 && depth > 0) depth--;
      m.pulse(3'h1 << k, 3'h0, 1'b0, s, 16'h0000);
      cmp_bit(depth > 0, act);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rstn_i = 1'b0;
      error_cnt = 0;
      cmp_count = 0;
      void'($urandom(88));
      do_reset();
      foreach (ra[i]) acc(1'b0, `MMU_PAGE_NUM, ra[i], 8'h00);
      acc(1'b0, 8'h00, `MMU_ISR_OFS, 8'h00);
      acc(1'b1, `MMU_PAGE_NUM, 8'hf5, 8'h3c);
      acc(1'b0, `MMU_PAGE_NUM, 8'he0, 8'h00);
      $display("test reset_and_map done");
      foreach (ra[i]) begin
         acc(1'b1, `MMU_PAGE_NUM, ra[i], 8'hc0 | 8'($urandom));
         acc(1'b0, `MMU_PAGE_NUM, ra[i], 8'h00);
      end
      acc(1'b1, `MMU_PAGE_NUM, `MMU_EXTENDED_MODE_REGISTER_TWO_OFS, 8'h00);
      $display("test register_access done");
      for (int i = 0; i < 4; i++) begin
         xl(1, 1'b0, {i[1:0], 14'($urandom)});
         xl(2, i[0], 16'($urandom));
         xl(0, i[1], 16'($urandom));
      end
      $display("test translation done");
      ev(0, 6'h00);
      xl(0, 1'b0, 16'h1234);
      ev(2, 6'($urandom));
      xl(0, 1'b0, 16'h5678);
      acc(1'b1, `MMU_PAGE_NUM, `MMU_CSR_OFS, 8'($urandom));
      xl(1, 1'b0, 16'hc001);
      ev(1, 6'h2a);
      xl(0, 1'b0, 16'h0100);
      acc(1'b0, `MMU_PAGE_NUM, `MMU_CSR_OFS, 8'h00);
      $display("test compatible_interrupt done");
      acc(1'b1, `MMU_PAGE_NUM, `MMU_EXTENDED_MODE_REGISTER_TWO_OFS, 8'h40);
      acc(1'b0, `MMU_PAGE_NUM, `MMU_EXTENDED_MODE_REGISTER_TWO_OFS, 8'h00);
      ev(0, 6'h00);
      xl(0, 1'b0, 16'h4321);
      ev(2, 6'($urandom));
      xl(0, 1'b0, 16'h8765);
      xl(1, 1'b0, 16'h7ffe);
      ev(1, 6'h2b);
      xl(0, 1'b0, 16'hfffe);
      acc(1'b0, `MMU_PAGE_NUM, `MMU_CSR_OFS, 8'h00);
      $display("test saving_interrupt done");
      acc(1'b1, `MMU_PAGE_NUM, `MMU_EXTENDED_MODE_REGISTER_TWO_OFS, 8'h20);
      for (int i = 0; i < 4; i++) acc(1'b1, 8'h00, 8'he0 + 8'(i), 8'($urandom));
      acc(1'b0, 8'h00, 8'he1, 8'h00);
      acc(1'b1, `MMU_PAGE_NUM, 8'hf0, 8'h55);
      for (int i = 0; i < 4; i++) xl(1, 1'b0, {i[1:0], 14'($urandom)});
      $display("test page_relocation done");
      do_reset();
      acc(1'b0, `MMU_PAGE_NUM, `MMU_EXTENDED_MODE_REGISTER_TWO_OFS, 8'h00);
      xl(0, 1'b0, 16'h2468);
      $display("test second_reset done");
      repeat (3) @(posedge clock_i);
      wrap_up();
   end
endmodule
